// *** smbus_pkg.sv ***
// Shared constants, codes and types of the two-wire bus controller
package smbus_pkg;
   localparam logic [7:0] ADR_STATE_CODE = 8'hC1;
   localparam logic [7:0] ADR_DATA_BYTE = 8'hC2;
   localparam logic [7:0] ADR_OWN_ADDR = 8'hC3;
   localparam logic [7:0] ADR_RATE_PRESET = 8'hCF;
   localparam logic [7:0] RST_STATE_CODE = 8'h00;
   localparam logic [7:0] RST_DATA_BYTE = 8'h00;
   localparam logic [7:0] RST_OWN_ADDR = 8'h00;
   localparam logic [7:0] RST_RATE_PRESET = 8'h00;
   localparam int OWN_ADDR_MSB = 7;
   localparam int OWN_ADDR_LSB = 1;
   localparam int GC_ENABLE_BIT = 0;
   localparam logic [7:0] GC_ADDRESS = 8'h00;
   localparam logic [7:0] RATE_LAST = 8'hFF;
   localparam logic [8:0] FREE_ROLL_END = 9'h100;
   localparam logic [3:0] BFT_ROLLS = 4'hA;
   localparam logic [3:0] ACK_BIT = 4'h8;
   localparam logic [7:0] CODE_START = 8'h08;
   localparam logic [7:0] CODE_RSTART = 8'h10;
   localparam logic [7:0] CODE_AW_ACK = 8'h18;
   localparam logic [7:0] CODE_AW_NACK = 8'h20;
   localparam logic [7:0] CODE_TX_ACK = 8'h28;
   localparam logic [7:0] CODE_TX_NACK = 8'h30;
   localparam logic [7:0] CODE_ARB_LOST = 8'h38;
   localparam logic [7:0] CODE_AR_ACK = 8'h40;
   localparam logic [7:0] CODE_AR_NACK = 8'h48;
   localparam logic [7:0] CODE_RX_ACK = 8'h50;
   localparam logic [7:0] CODE_RX_NACK = 8'h58;
   localparam logic [7:0] CODE_IDLE = 8'hF8;

   typedef struct packed {
      logic scl;
      logic sda;
   } pins_s;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic [7:0] wdata;
   } sfr_req_s;

   typedef enum logic [3:0] {
      ST_IDLE, ST_START, ST_WAIT_SI, ST_BIT_LO, ST_BIT_HI,
      ST_STOP_A, ST_STOP_B, ST_STOP_C, ST_RS_A, ST_RS_B
   } ctl_state_e;

   typedef enum logic [1:0] {PH_ADDR, PH_TX, PH_RX} phase_e;
endpackage

// *** pin_sync.sv ***
// Bus pin sampler on the link clock with crossing into the system clock
`timescale 1ns/1ps
module pin_sync (
   input wire logic link_clk_i,
   input wire logic clk_i,
   input wire logic reset_i,
   input wire smbus_pkg::pins_s pins_i,
   output smbus_pkg::pins_s pins_o
);
   import smbus_pkg::*;

   pins_s link_meta_r;
   pins_s link_sync_r;
   pins_s sys_meta_r;
   pins_s sys_sync_r;

   // Pins are asynchronous to both clocks
   always_ff @(posedge link_clk_i)
   begin
      link_meta_r <= pins_i;
      link_sync_r <= link_meta_r;
   end

   // Idle bus level is high on both wires
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         sys_meta_r <= '1;
         sys_sync_r <= '1;
      end
      else
      begin
         sys_meta_r <= link_sync_r;
         sys_sync_r <= sys_meta_r;
      end
   end

   assign pins_o = sys_sync_r;
endmodule // pin_sync

// *** smbus_core.sv ***
// Two-wire bus controller: rate timer, data byte, address match, status
`timescale 1ns/1ps
module smbus_core (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic link_clk_i,
   input wire smbus_pkg::sfr_req_s sfr_i,
   output logic [7:0] sfr_rdata_o,
   input wire logic enable_i,
   input wire logic start_request_i,
   input wire logic stop_request_i,
   input wire logic acknowledge_assert_flag_i,
   input wire logic si_clear_i,
   output logic si_o,
   output logic stop_done_o,
   output logic master_o,
   output logic bus_busy_o,
   output logic own_addr_hit_o,
   output logic general_call_hit_o,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic scl_oe_o,
   output logic sda_o,
   output logic sda_oe_o
);
   import smbus_pkg::*;

   pins_s pins;
   pins_s prev_r;
   ctl_state_e state_r;
   phase_e phase_r;
   logic [3:0] bit_cnt_r;
   logic [3:0] sbit_r;
   logic [3:0] ft_roll_r;
   logic [8:0] ft_cnt_r;
   logic [7:0] rate_cnt_r;
   logic [7:0] preset_r;
   logic [7:0] own_r;
   logic [7:0] data_r;
   logic [7:0] code_r;
   logic [7:0] rdata_r;
   logic rd_dir_r, rs_r, master_r, scl_oe_r, sda_oe_r, si_r, stop_done_r;
   logic busy_r, slave_active_r, cmp_r, own_hit_r, gc_hit_r, drive_lvl_r;
   logic timed, run, tick, m_sample, arb_lost, ack_seen, drive_bit;
   logic scl_rise, start_seen, stop_seen, s_sample, addr_done, ft_done;
   logic [7:0] addr_byte;

   pin_sync u_pin_sync (
      .link_clk_i(link_clk_i),
      .clk_i(clk_i),
      .reset_i(reset_i),
      .pins_i({scl_i, sda_i}),
      .pins_o(pins)
   );

   assign timed = state_r inside {ST_START, ST_BIT_LO, ST_BIT_HI, ST_STOP_A,
                                  ST_STOP_B, ST_STOP_C, ST_RS_A, ST_RS_B};
   // Timer waits for a released SCL to read high: clock stretching
   assign run = timed && (scl_oe_r || pins.scl);
   assign tick = run && rate_cnt_r == RATE_LAST;
   assign m_sample = state_r == ST_BIT_HI && tick;
   assign ack_seen = !pins.sda;
   assign arb_lost = m_sample && bit_cnt_r < ACK_BIT && phase_r != PH_RX &&
                     data_r[7] && !pins.sda;
   assign drive_bit = (bit_cnt_r == ACK_BIT) ?
                      (phase_r == PH_RX && acknowledge_assert_flag_i) :
                      (phase_r != PH_RX && !data_r[7]);
   assign scl_rise = pins.scl && !prev_r.scl;
   assign start_seen = prev_r.scl && pins.scl && prev_r.sda && !pins.sda;
   assign stop_seen = prev_r.scl && pins.scl && !prev_r.sda && pins.sda;
   assign s_sample = !master_r && slave_active_r && scl_rise;
   assign addr_byte = {data_r[6:0], pins.sda};
   assign addr_done = s_sample && sbit_r == 4'h7 && cmp_r;
   assign ft_done = busy_r && pins.scl && ft_cnt_r == FREE_ROLL_END &&
                    ft_roll_r == BFT_ROLLS - 4'h1;

   // Half-period timer; low phase runs preset..FF
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         rate_cnt_r <= RST_RATE_PRESET;
      else if (!run || tick)
         rate_cnt_r <= preset_r;
      else
         rate_cnt_r <= rate_cnt_r + 8'h01;
   end

   // Master sequencer, status code and serial flag
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         state_r <= ST_IDLE;
         phase_r <= PH_ADDR;
         bit_cnt_r <= 4'h0;
         rd_dir_r <= 1'b0;
         rs_r <= 1'b0;
         master_r <= 1'b0;
         scl_oe_r <= 1'b0;
         sda_oe_r <= 1'b0;
         code_r <= RST_STATE_CODE;
         si_r <= 1'b0;
         stop_done_r <= 1'b0;
      end
      else
      begin
         stop_done_r <= 1'b0;
         // Later set in this block wins over the clear
         if (si_clear_i)
            si_r <= 1'b0;
         if (!enable_i)
         begin
            state_r <= ST_IDLE;
            master_r <= 1'b0;
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
         end
         else
         begin
            case (state_r)
               ST_IDLE:
               begin
                  // Slave side stretches only a low it already sees
                  scl_oe_r <= si_r && (scl_oe_r || !pins.scl);
                  sda_oe_r <= 1'b0;
                  if (start_request_i && !busy_r && !si_r)
                  begin
                     state_r <= ST_START;
                     master_r <= 1'b1;
                     rs_r <= 1'b0;
                     scl_oe_r <= 1'b0;
                     sda_oe_r <= 1'b1;
                  end
               end
               ST_START:
                  if (tick)
                  begin
                     scl_oe_r <= 1'b1;
                     code_r <= rs_r ? CODE_RSTART : CODE_START;
                     si_r <= 1'b1;
                     phase_r <= PH_ADDR;
                     state_r <= ST_WAIT_SI;
                  end
               ST_WAIT_SI:
                  // SCL stays low until the flag is cleared
                  if (!si_r)
                  begin
                     if (stop_request_i)
                        state_r <= ST_STOP_A;
                     else if (start_request_i && code_r != CODE_START &&
                              code_r != CODE_RSTART)
                        state_r <= ST_RS_A;
                     else
                     begin
                        state_r <= ST_BIT_LO;
                        bit_cnt_r <= 4'h0;
                        if (phase_r == PH_ADDR)
                           rd_dir_r <= data_r[0];
                     end
                  end
               ST_BIT_LO:
               begin
                  // SDA moves a cycle after SCL fell, keeping hold time
                  sda_oe_r <= drive_bit;
                  if (tick)
                  begin
                     scl_oe_r <= 1'b0;
                     state_r <= ST_BIT_HI;
                  end
               end
               ST_BIT_HI:
                  if (tick)
                  begin
                     scl_oe_r <= 1'b1;
                     if (arb_lost)
                     begin
                        master_r <= 1'b0;
                        scl_oe_r <= 1'b0;
                        sda_oe_r <= 1'b0;
                        code_r <= CODE_ARB_LOST;
                        si_r <= 1'b1;
                        state_r <= ST_IDLE;
                     end
                     else if (bit_cnt_r == ACK_BIT)
                     begin
                        si_r <= 1'b1;
                        state_r <= ST_WAIT_SI;
                        case (phase_r)
                           PH_ADDR:
                           begin
                              if (rd_dir_r)
                                 code_r <= ack_seen ? CODE_AR_ACK
                                                    : CODE_AR_NACK;
                              else
                                 code_r <= ack_seen ? CODE_AW_ACK
                                                    : CODE_AW_NACK;
                              phase_r <= (rd_dir_r && ack_seen) ? PH_RX
                                                                 : PH_TX;
                           end
                           PH_TX:
                              code_r <= ack_seen ? CODE_TX_ACK
                                                 : CODE_TX_NACK;
                           default:
                              code_r <= sda_oe_r ? CODE_RX_ACK
                                                 : CODE_RX_NACK;
                        endcase
                     end
                     else
                     begin
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        state_r <= ST_BIT_LO;
                     end
                  end
               ST_STOP_A:
               begin
                  sda_oe_r <= 1'b1;
                  if (tick)
                  begin
                     scl_oe_r <= 1'b0;
                     state_r <= ST_STOP_B;
                  end
               end
               ST_STOP_B:
                  if (tick)
                  begin
                     sda_oe_r <= 1'b0;
                     state_r <= ST_STOP_C;
                  end
               ST_STOP_C:
                  if (tick)
                  begin
                     // A pending start relaunches from idle once free
                     master_r <= 1'b0;
                     stop_done_r <= 1'b1;
                     code_r <= CODE_IDLE;
                     state_r <= ST_IDLE;
                  end
               ST_RS_A:
               begin
                  sda_oe_r <= 1'b0;
                  if (tick)
                  begin
                     scl_oe_r <= 1'b0;
                     state_r <= ST_RS_B;
                  end
               end
               ST_RS_B:
                  if (tick)
                  begin
                     sda_oe_r <= 1'b1;
                     rs_r <= 1'b1;
                     state_r <= ST_START;
                  end
               default:
                  state_r <= ST_IDLE;
            endcase
         end
      end
   end

   // Data byte: bus shifting outranks a stray software write
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         data_r <= RST_DATA_BYTE;
      else if ((m_sample && bit_cnt_r < ACK_BIT) || s_sample)
         data_r <= {data_r[6:0], pins.sda};
      else if (sfr_i.wr && sfr_i.addr == ADR_DATA_BYTE)
         data_r <= sfr_i.wdata;
   end

   // Slave-side tracking and own address compare
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         prev_r <= '1;
         slave_active_r <= 1'b0;
         sbit_r <= 4'h0;
         cmp_r <= 1'b0;
         own_hit_r <= 1'b0;
         gc_hit_r <= 1'b0;
      end
      else
      begin
         prev_r <= pins;
         own_hit_r <= 1'b0;
         gc_hit_r <= 1'b0;
         if (arb_lost)
         begin
            // Take over mid-byte so the remaining bits still land
            slave_active_r <= 1'b1;
            sbit_r <= bit_cnt_r + 4'h1;
            cmp_r <= phase_r == PH_ADDR;
         end
         else if (master_r)
            slave_active_r <= 1'b0;
         else if (start_seen)
         begin
            slave_active_r <= 1'b1;
            sbit_r <= 4'h0;
            cmp_r <= 1'b1;
         end
         else if (stop_seen)
            slave_active_r <= 1'b0;
         else if (s_sample)
         begin
            sbit_r <= sbit_r + 4'h1;
            if (sbit_r == 4'h7)
            begin
               slave_active_r <= 1'b0;
               if (cmp_r)
               begin
                  own_hit_r <= addr_byte[7:1] ==
                               own_r[OWN_ADDR_MSB:OWN_ADDR_LSB];
                  gc_hit_r <= addr_byte == GC_ADDRESS &&
                              own_r[GC_ENABLE_BIT];
               end
            end
         end
      end
   end

   // Bus busy and free timeout, counted while SCL stays high
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         busy_r <= 1'b0;
         ft_cnt_r <= {1'b0, RST_RATE_PRESET};
         ft_roll_r <= 4'h0;
      end
      else
      begin
         if (start_seen)
            busy_r <= 1'b1;
         else if (stop_seen || ft_done)
            busy_r <= 1'b0;
         if (!pins.scl || !busy_r)
         begin
            ft_cnt_r <= {1'b0, preset_r};
            ft_roll_r <= 4'h0;
         end
         else if (ft_cnt_r == FREE_ROLL_END)
         begin
            ft_cnt_r <= {1'b0, preset_r};
            ft_roll_r <= (ft_roll_r == BFT_ROLLS - 4'h1) ? 4'h0
                                                         : ft_roll_r + 4'h1;
         end
         else
            ft_cnt_r <= ft_cnt_r + 9'h001;
      end
   end

   // Register file; status writes are dropped
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         own_r <= RST_OWN_ADDR;
         preset_r <= RST_RATE_PRESET;
         rdata_r <= 8'h00;
         drive_lvl_r <= 1'b0;
      end
      else
      begin
         drive_lvl_r <= 1'b0;
         if (sfr_i.wr && sfr_i.addr == ADR_OWN_ADDR)
            own_r <= sfr_i.wdata;
         if (sfr_i.wr && sfr_i.addr == ADR_RATE_PRESET)
            preset_r <= sfr_i.wdata;
         case (sfr_i.addr)
            ADR_STATE_CODE: rdata_r <= code_r;
            ADR_DATA_BYTE: rdata_r <= data_r;
            ADR_OWN_ADDR: rdata_r <= own_r;
            ADR_RATE_PRESET: rdata_r <= preset_r;
            default: rdata_r <= 8'h00;
         endcase
      end
   end

   assign sfr_rdata_o = rdata_r;
   assign si_o = si_r;
   assign stop_done_o = stop_done_r;
   assign master_o = master_r;
   assign bus_busy_o = busy_r;
   assign own_addr_hit_o = own_hit_r;
   assign general_call_hit_o = gc_hit_r;
   assign scl_o = drive_lvl_r;
   assign sda_o = drive_lvl_r;
   assign scl_oe_o = scl_oe_r;
   assign sda_oe_o = sda_oe_r;

   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);

   property p_rate_reload;
      tick |=> rate_cnt_r == $past(preset_r);
   endproperty
   a_rate_reload: assert property (p_rate_reload)
      else $error("rate timer did not reload");

   property p_low_to_high;
      enable_i && state_r == ST_BIT_LO && tick |=>
         state_r == ST_BIT_HI && !scl_oe_r;
   endproperty
   a_low_to_high: assert property (p_low_to_high)
      else $error("SCL not released at end of low phase");

   property p_free_timeout;
      ft_done && !start_seen |=> !busy_r;
   endproperty
   a_free_timeout: assert property (p_free_timeout)
      else $error("bus free timeout did not free bus");

   property p_msb_shift;
      m_sample && bit_cnt_r < ACK_BIT |=>
         data_r == {$past(data_r[6:0]), $past(pins.sda)};
   endproperty
   a_msb_shift: assert property (p_msb_shift)
      else $error("received bit not shifted in at bit 0");

   property p_arb_lost;
      enable_i && arb_lost |=>
         code_r == CODE_ARB_LOST && si_r && !master_r && slave_active_r;
   endproperty
   a_arb_lost: assert property (p_arb_lost)
      else $error("arbitration loss not reported");

   property p_own_match;
      addr_done |=> own_hit_r == ($past(addr_byte[7:1]) ==
                                  $past(own_r[OWN_ADDR_MSB:OWN_ADDR_LSB]));
   endproperty
   a_own_match: assert property (p_own_match)
      else $error("own address compare wrong");

   property p_gc_match;
      addr_done |=> gc_hit_r == ($past(addr_byte) == GC_ADDRESS &&
                                 $past(own_r[GC_ENABLE_BIT]));
   endproperty
   a_gc_match: assert property (p_gc_match)
      else $error("general call compare wrong");

   property p_master_ignore;
      master_r |=> !own_hit_r && !gc_hit_r;
   endproperty
   a_master_ignore: assert property (p_master_ignore)
      else $error("address hit while master");

   property p_code_low_zero;
      si_r |-> code_r[2:0] == 3'h0;
   endproperty
   a_code_low_zero: assert property (p_code_low_zero)
      else $error("status code low bits not zero");

   property p_start_code;
      enable_i && state_r == ST_START && tick |=>
         si_r && code_r == ($past(rs_r) ? CODE_RSTART : CODE_START);
   endproperty
   a_start_code: assert property (p_start_code)
      else $error("start code wrong");

   property p_hold_low;
      // Dropping the enable legally lets go of the bus
      enable_i && state_r == ST_WAIT_SI && si_r |=>
         scl_oe_r ##1 (scl_oe_r || !$past(enable_i));
   endproperty
   a_hold_low: assert property (p_hold_low)
      else $error("SCL released while flag set");

   property p_idle_no_flag;
      enable_i && state_r == ST_STOP_C && tick && !si_r && !si_clear_i |=>
         code_r == CODE_IDLE && !si_r && stop_done_r;
   endproperty
   a_idle_no_flag: assert property (p_idle_no_flag)
      else $error("idle code set the flag");

   c_start: cover property (state_r == ST_START && tick);
   c_rx_byte: cover property (si_r && code_r == CODE_RX_ACK);
   c_arb: cover property (arb_lost);
   c_own_hit: cover property (own_hit_r);
endmodule // smbus_core

// *** smbus_target_model.sv ***
// Target device model answering on the shared two-wire bus
`timescale 1ns/1ps
module smbus_target_model #(
   parameter logic [6:0] ADDR = 7'h2A,
   parameter logic [7:0] RD = 8'hC3
)
(
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic nack_i,
   output logic sda_oe_o,
   output logic [7:0] got_o
);
   int cnt = 9;
   logic [7:0] sh = 8'h00;
   logic [7:0] out = 8'h00;
   logic adr = 1'b0;
   logic sel = 1'b0;
   logic rd = 1'b0;
   logic mack = 1'b0;
   initial sda_oe_o = 1'b0;
   initial got_o = 8'h00;
   // Start restarts framing; stop ends it until the next start
   always @(sda_i)
      if (scl_i === 1'b1)
      begin
         cnt = sda_i ? 9 : 0;
         adr = !sda_i;
         sel = 1'b0;
      end
   always @(posedge scl_i)
      if (cnt < 8)
      begin
         sh = {sh[6:0], sda_i};
         cnt++;
      end
      else if (cnt == 10)
         mack = !sda_i;
   // Only moves while SCL low, so never a false start or stop
   always @(negedge scl_i)
      if (cnt == 8)
      begin
         if (adr)
            {sel, rd} = {sh[7:1] == ADDR, sh[0]};
         else if (!rd)
            got_o = sh;
         sda_oe_o = sel && (adr || (!rd && !nack_i));
         cnt = 10;
      end
      else if (cnt == 10)
      begin
         out = adr ? RD : out + 8'h01;
         sda_oe_o = sel && rd && (adr || mack) && !out[7];
         adr = 1'b0;
         cnt = 0;
      end
      else if (cnt > 0 && cnt < 8 && sel && rd)
         sda_oe_o = !out[7 - cnt];
endmodule // smbus_target_model

// *** smbus_clock_data_status_tb.sv ***
// Self-checking bench for the two-wire bus controller
`timescale 1ns/1ps
module smbus_clock_data_status_tb;
   import smbus_pkg::*;
   logic clk_i = 1'b0;
   logic link_clk_i = 1'b0;
   logic reset_i = 1'b1;
   sfr_req_s sfr_i = '0;
   logic enable_i = 1'b0;
   logic start_i = 1'b0;
   logic stop_i = 1'b0;
   logic ack_i = 1'b1;
   logic si_clear_i = 1'b0;
   logic nack_i = 1'b0;
   logic si_o, stop_done_o, master_o, scl_oe_o, sda_oe_o, t_oe;
   logic bus_busy_o, own_hit, gc_hit, scl_lvl, sda_lvl;
   logic scl_pull = 1'b0;
   logic sda_pull = 1'b0;
   logic [7:0] sfr_rdata_o, got, v;
   logic [7:0] adrs [5] = '{8'hC1, 8'hC2, 8'hC3, 8'hCF, 8'h55};
   logic [7:0] rb [5] = '{8'h00, 8'h00, 8'hA5, 8'hEC, 8'h00};
   wire logic scl = !(scl_oe_o || scl_pull);
   wire logic sda = !(sda_oe_o || t_oe || sda_pull);
   int fail_count = 0;
   int cmp_count = 0;
   int run = 0;
   int low_len = 0;
   int own_hits = 0;
   int gc_hits = 0;
   always #20 clk_i = !clk_i;
   initial #3 forever #7.5 link_clk_i = !link_clk_i;
   smbus_core dut (.clk_i(clk_i), .reset_i(reset_i),
      .link_clk_i(link_clk_i), .sfr_i(sfr_i), .sfr_rdata_o(sfr_rdata_o),
      .enable_i(enable_i), .start_request_i(start_i),
      .stop_request_i(stop_i), .acknowledge_assert_flag_i(ack_i),
      .si_clear_i(si_clear_i), .si_o(si_o), .stop_done_o(stop_done_o),
      .master_o(master_o), .bus_busy_o(bus_busy_o),
      .own_addr_hit_o(own_hit), .general_call_hit_o(gc_hit),
      .scl_i(scl), .sda_i(sda), .scl_o(scl_lvl),
      .scl_oe_o(scl_oe_o), .sda_o(sda_lvl), .sda_oe_o(sda_oe_o));
   smbus_target_model #(.ADDR(7'h2A), .RD(8'hC3)) peer (.scl_i(scl),
      .sda_i(sda), .nack_i(nack_i), .sda_oe_o(t_oe), .got_o(got));
   // Length of the last finished SCL low phase
   always @(posedge clk_i)
      if (scl_oe_o === 1'b1)
         run <= run + 1;
      else if (run != 0)
      begin
         low_len <= run;
         run <= 0;
      end
   // Address hits are one-cycle pulses, so count them
   always @(posedge clk_i)
      if (own_hit === 1'b1)
         own_hits <= own_hits + 1;
   always @(posedge clk_i)
      if (gc_hit === 1'b1)
         gc_hits <= gc_hits + 1;
   task automatic chk(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i) sfr_i <= '{a, 1'b1, d};
      @(posedge clk_i) sfr_i.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i) sfr_i <= '{a, 1'b0, 8'h00};
      repeat (2) @(posedge clk_i);
      #1 d = sfr_rdata_o;
   endtask
   // Bounded, since a stop never raises the flag
   task automatic clr_wait(input logic [7:0] code);
      int n;
      n = 0;
      @(posedge clk_i) si_clear_i <= 1'b1;
      @(posedge clk_i) si_clear_i <= 1'b0;
      @(posedge clk_i);
      while (si_o !== 1'b1 && n < 5000)
      begin
         @(posedge clk_i);
         if (stop_done_o === 1'b1)
            stop_i <= 1'b0;
         n++;
      end
      rd(ADR_STATE_CODE, v);
      chk("state code", v, code);
   endtask
   task automatic go(input logic [7:0] d, input logic [7:0] code);
      wr(ADR_DATA_BYTE, d);
      clr_wait(code);
   endtask
   // Foreign master: START, one address byte, STOP; slow for the sync
   task automatic ext_addr(input logic [7:0] b);
      repeat (30) @(posedge clk_i);
      sda_pull <= 1'b1;
      for (int i = 7; i >= 0; i--)
      begin
         repeat (30) @(posedge clk_i);
         scl_pull <= 1'b1;
         repeat (30) @(posedge clk_i);
         sda_pull <= !b[i];
         repeat (30) @(posedge clk_i);
         scl_pull <= 1'b0;
      end
      repeat (30) @(posedge clk_i);
      scl_pull <= 1'b1;
      repeat (30) @(posedge clk_i);
      sda_pull <= 1'b1;
      repeat (30) @(posedge clk_i);
      scl_pull <= 1'b0;
      repeat (30) @(posedge clk_i);
      sda_pull <= 1'b0;
   endtask
   task automatic tally_and_finish();
      if (fail_count == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      repeat (60000) @(posedge clk_i);
      fail_count++;
      tally_and_finish();
   end
   initial
   begin
      repeat (10) @(posedge clk_i);
      reset_i <= 1'b0;
      foreach (adrs[i])
      begin
         rd(adrs[i], v);
         chk("reset value", v, 8'h00);
      end
      wr(ADR_RATE_PRESET, 8'hEC);
      wr(ADR_OWN_ADDR, 8'hA5);
      wr(8'h55, 8'h77);
      foreach (adrs[i])
      begin
         rd(adrs[i], v);
         chk("readback", v, rb[i]);
      end
      @(posedge clk_i) enable_i <= 1'b1;
      start_i <= 1'b1;
      clr_wait(CODE_START);
      chk("master", {7'h00, master_o}, 8'h01);
      chk("busy", {7'h00, bus_busy_o}, 8'h01);
      @(posedge clk_i) start_i <= 1'b0;
      go(8'h54, CODE_AW_ACK);
      go(8'h96, CODE_TX_ACK);
      chk("sent byte", got, 8'h96);
      chk("drive level", {6'h00, scl_lvl, sda_lvl}, 8'h00);
      chk("scl low", low_len[7:0], 8'h14);
      rd(ADR_DATA_BYTE, v);
      chk("data byte", v, 8'h96);
      @(posedge clk_i) start_i <= 1'b1;
      clr_wait(CODE_RSTART);
      @(posedge clk_i) start_i <= 1'b0;
      go(8'h55, CODE_AR_ACK);
      go(8'hFF, CODE_RX_ACK);
      rd(ADR_DATA_BYTE, v);
      chk("rx byte", v, 8'hC3);
      @(posedge clk_i) ack_i <= 1'b0;
      go(8'hFF, CODE_RX_NACK);
      rd(ADR_DATA_BYTE, v);
      chk("rx byte", v, 8'hC4);
      @(posedge clk_i) stop_i <= 1'b1;
      clr_wait(CODE_IDLE);
      chk("flag", {7'h00, si_o}, 8'h00);
      ext_addr(8'hA4);
      chk("own hit", own_hits[7:0], 8'h01);
      chk("gc hit", gc_hits[7:0], 8'h00);
      ext_addr(8'h00);
      chk("gc hit", gc_hits[7:0], 8'h01);
      chk("own hit", own_hits[7:0], 8'h01);
      wr(ADR_OWN_ADDR, 8'hA4);
      ext_addr(8'h00);
      chk("gc hit", gc_hits[7:0], 8'h01);
      // START with SCL left high: free after 10 x 21 clocks
      @(posedge clk_i) sda_pull <= 1'b1;
      repeat (150) @(posedge clk_i);
      chk("busy", {7'h00, bus_busy_o}, 8'h01);
      repeat (110) @(posedge clk_i);
      chk("busy", {7'h00, bus_busy_o}, 8'h00);
      @(posedge clk_i) sda_pull <= 1'b0;
      repeat (30) @(posedge clk_i);
      @(posedge clk_i) start_i <= 1'b1;
      clr_wait(CODE_START);
      @(posedge clk_i) start_i <= 1'b0;
      sda_pull <= 1'b1;
      go(8'h80, CODE_ARB_LOST);
      chk("master", {7'h00, master_o}, 8'h00);
      @(posedge clk_i) sda_pull <= 1'b0;
      @(posedge clk_i) start_i <= 1'b1;
      clr_wait(CODE_START);
      @(posedge clk_i) start_i <= 1'b0;
      go(8'hA4, CODE_AW_NACK);
      @(posedge clk_i) stop_i <= 1'b1;
      start_i <= 1'b1;
      clr_wait(CODE_START);
      @(posedge clk_i) start_i <= 1'b0;
      go(8'h41, CODE_AR_NACK);
      @(posedge clk_i) stop_i <= 1'b1;
      start_i <= 1'b1;
      clr_wait(CODE_START);
      @(posedge clk_i) start_i <= 1'b0;
      nack_i <= 1'b1;
      go(8'h54, CODE_AW_ACK);
      go(8'h0F, CODE_TX_NACK);
      chk("sent byte", got, 8'h0F);
      @(posedge clk_i) stop_i <= 1'b1;
      clr_wait(CODE_IDLE);
      chk("own hit", own_hits[7:0], 8'h01);
      tally_and_finish();
   end
endmodule // smbus_clock_data_status_tb
